// ---- hdl/lane_verifier_map.svh ----
// register offsets, field positions, codes and timing counts of the lane verifier
`ifndef LANE_VERIFIER_MAP_SVH
`define LANE_VERIFIER_MAP_SVH

`define OFS_SYNC_LOAD 8'h0E
`define OFS_MISMATCH_SEARCH 8'h0F
`define OFS_PATTERN_CONFIG 8'h10
`define OFS_CUSTOM_LOW 8'h11
`define OFS_CUSTOM_MID 8'h12
`define OFS_CUSTOM_HIGH 8'h13
`define OFS_THRESHOLD 8'h14
`define OFS_TEST_CONTROL 8'h15
`define OFS_DATAPATH_SELECT 8'h16
`define OFS_TEST_FLAGS 8'h17
`define OFS_COUNT_FIRST 8'h18
`define OFS_COUNT_LAST 8'h1F

`define RESET_BYTE 8'h00
`define BIT_CUSTOM_LEN 7
`define BIT_LEN_HI 5
`define BIT_LEN_LO 3
`define BIT_SEL_HI 2
`define BIT_ALIGN_DONE 7
`define BIT_COUNTER_CLEAR 4
`define BIT_FLAG_CLEAR 3

`define SEL_DISABLED 3'h0
`define SEL_PRBS 3'h1
`define SEL_CLOCK 3'h2
`define SEL_CUSTOM 3'h3
`define SEL_TIMING_BIT 2

`define CHK_DISPARITY 3'h0
`define CHK_FIFO_ERROR 3'h1
`define CHK_OVERFLOW 3'h2
`define CHK_UNDERFLOW 3'h3
`define CHK_DESKEW 3'h4

`define FLAG_ERROR 3'h0
`define FLAG_MISMATCH 3'h1
`define FLAG_SEARCH 3'h2
`define FLAG_SYNC 3'h3

`define CLOCK_PATTERN 20'h07C1F
`define LOCK_RUN 6'h28
`define SEARCH_LIMIT_SHIFT 10
// one received bit per clock, so one unit interval is one cycle
`define SYNC_WIDTH_UI 8
`define UI_PER_CYCLE 1
`define SYNC_WIDTH_CYCLES (`SYNC_WIDTH_UI / `UI_PER_CYCLE)

`endif

// ---- hdl/lane_verifier_pkg.sv ----
// types shared by the lane pattern verifier
package lane_verifier_pkg;
    typedef struct packed {
        logic [2:0] timeout;
        logic [2:0] select;
        logic [2:0] prbsLength;
        logic customLenSel;
        logic [19:0] customPattern;
    } laneCfg_type;

    typedef struct packed {
        logic [3:0] disparity;
        logic [3:0] fifoError;
        logic [3:0] overflow;
        logic [3:0] underflow;
        logic [3:0] deskew;
    } dpErr_type;

    typedef enum logic [1:0] {V_IDLE, V_SEARCH, V_TRACK, V_TIMING} verState_type;
endpackage

// ---- hdl/lane_pattern_verifier.sv ----
// per-lane pattern verifier, error counters and test flags with register port
`timescale 1ns/1ps
`default_nettype none
`include "lane_verifier_map.svh"

module lane_pattern_verifier
    import lane_verifier_pkg::*;
#(
    parameter int LANES = 4,
    parameter int COUNT_W = 12
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    output var logic [7:0] regRdData,
    input wire logic [LANES-1:0] rxBit,
    input wire logic [2:0] verifierTimeout,
    input wire dpErr_type dpErr,
    input wire logic laneAlignDone,
    output var logic [LANES-1:0] liveTestFlag
);
    // ****************************************
    // elaboration checks
    // ****************************************
    // the register map packs exactly four lanes and 12-bit counts
    if (LANES != 4) begin : g_badLanes
        $error("lane count must be 4");
    end
    if (COUNT_W != 12) begin : g_badWidth
        $error("count width must be 12");
    end

    // ****************************************
    // registers
    // ****************************************
    logic [3:0] verifierLoad;
    logic customLenSel;
    logic [2:0] prbsLength;
    logic [2:0] patternSelect;
    logic [7:0] customLow;
    logic [7:0] customMid;
    logic [3:0] customHigh;
    logic [2:0] retainThreshold;
    logic errorCounterClear;
    logic stickyFlagClear;
    logic [2:0] testFlagSource;
    logic [3:0] datapathVerifyEnable;
    logic [2:0] datapathCheckSelect;
    logic clearPrev;
    logic clearPulse;
    logic [3:0] patternSyncPulse;
    logic [3:0] verifyMismatch;
    logic [3:0] searchInProgress;
    logic [3:0] patternErr;
    logic [3:0] laneErr;
    logic [3:0] dpSource;
    logic [3:0] latchedTestFlag;
    logic [COUNT_W-1:0] bitErrorCount [LANES];
    laneCfg_type liveCfg;
    laneCfg_type activeCfg [LANES];
    logic [7:0] next_readData;

    wire regWr = regWrite;
    wire isWr = regWr;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            verifierLoad <= 4'h0;
            customLenSel <= 1'b0;
            prbsLength <= 3'h0;
            patternSelect <= `SEL_DISABLED;
            customLow <= `RESET_BYTE;
            customMid <= `RESET_BYTE;
            customHigh <= 4'h0;
            retainThreshold <= 3'h0;
            testFlagSource <= 3'h0;
            datapathVerifyEnable <= 4'h0;
            datapathCheckSelect <= `CHK_DISPARITY;
        end else if (isWr) begin
            case (regAddr)
                `OFS_SYNC_LOAD: verifierLoad <= regWrData[3:0];
                `OFS_PATTERN_CONFIG: begin
                    customLenSel <= regWrData[`BIT_CUSTOM_LEN];
                    prbsLength <= regWrData[`BIT_LEN_HI:`BIT_LEN_LO];
                    patternSelect <= regWrData[`BIT_SEL_HI:0];
                end
                `OFS_CUSTOM_LOW: customLow <= regWrData;
                `OFS_CUSTOM_MID: customMid <= regWrData;
                `OFS_CUSTOM_HIGH: customHigh <= regWrData[3:0];
                `OFS_THRESHOLD: retainThreshold <= regWrData[2:0];
                `OFS_TEST_CONTROL: testFlagSource <= regWrData[2:0];
                `OFS_DATAPATH_SELECT: begin
                    datapathVerifyEnable <= regWrData[7:4];
                    datapathCheckSelect <= regWrData[2:0];
                end
                default: ;
            endcase
        end
    end

    // clear bits only live for the cycle after the write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            errorCounterClear <= 1'b0;
            stickyFlagClear <= 1'b0;
            clearPrev <= 1'b0;
        end else begin
            errorCounterClear <= isWr && regAddr == `OFS_TEST_CONTROL
                && regWrData[`BIT_COUNTER_CLEAR];
            stickyFlagClear <= isWr && regAddr == `OFS_TEST_CONTROL
                && regWrData[`BIT_FLAG_CLEAR];
            clearPrev <= errorCounterClear;
        end
    end
    assign clearPulse = errorCounterClear && !clearPrev;

    // ****************************************
    // lane settings
    // ****************************************
    always_comb begin
        liveCfg.timeout = verifierTimeout;
        liveCfg.select = patternSelect;
        liveCfg.prbsLength = prbsLength;
        liveCfg.customLenSel = customLenSel;
        // upper bits stay out of a 16-bit pattern
        liveCfg.customPattern = {customLenSel ? customHigh : 4'h0, customMid, customLow};
    end

    function automatic logic [4:0] prbsOrder(input logic [2:0] len);
        case (len)
            3'h0: prbsOrder = 5'd7;
            3'h1: prbsOrder = 5'd11;
            3'h2: prbsOrder = 5'd23;
            3'h3: prbsOrder = 5'd31;
            3'h4, 3'h5: prbsOrder = 5'd15;
            default: prbsOrder = 5'd20;
        endcase
    endfunction

    function automatic logic [4:0] prbsTap(input logic [2:0] len);
        case (len)
            3'h0: prbsTap = 5'd6;
            3'h1: prbsTap = 5'd9;
            3'h2: prbsTap = 5'd18;
            3'h3: prbsTap = 5'd28;
            3'h4, 3'h5: prbsTap = 5'd14;
            default: prbsTap = 5'd3;
        endcase
    endfunction

    // ****************************************
    // per-lane verifier
    // ****************************************
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        laneCfg_type heldCfg;
        verState_type state;
        logic [30:0] history;
        logic [19:0] rotor;
        logic [5:0] matchRun;
        logic [2:0] missRun;
        logic [15:0] searchCount;
        logic [30:0] syncCount;
        logic [30:0] period;
        logic predicted;
        logic expected;
        logic isPrbs;
        logic wide;
        logic [19:0] seed;

        // settings follow the register while load is high, then freeze
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                heldCfg <= '0;
            end else if (verifierLoad[i]) begin
                heldCfg <= liveCfg;
            end
        end
        assign activeCfg[i] = verifierLoad[i] ? liveCfg : heldCfg;

        assign isPrbs = activeCfg[i].select == `SEL_PRBS;
        assign wide = activeCfg[i].select == `SEL_CLOCK || activeCfg[i].customLenSel;
        assign seed = activeCfg[i].select == `SEL_CLOCK ? `CLOCK_PATTERN
            : activeCfg[i].customPattern;
        assign predicted = history[prbsOrder(activeCfg[i].prbsLength) - 5'd1]
            ^ history[prbsTap(activeCfg[i].prbsLength) - 5'd1];
        assign expected = isPrbs ? predicted : (wide ? rotor[19] : rotor[15]);
        assign period = 31'((64'h1 << prbsOrder(activeCfg[i].prbsLength)) - 64'h1);

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                state <= V_IDLE;
                history <= '0;
                rotor <= '0;
                matchRun <= '0;
                missRun <= '0;
                searchCount <= '0;
            end else if (verifierLoad[i]) begin
                // reloading restarts the search from scratch
                state <= activeCfg[i].select[`SEL_TIMING_BIT] ? V_TIMING
                    : (activeCfg[i].select == `SEL_DISABLED ? V_IDLE : V_SEARCH);
                rotor <= seed;
                matchRun <= '0;
                missRun <= '0;
                searchCount <= '0;
            end else begin
                case (state)
                    V_SEARCH: begin
                        searchCount <= searchCount + 16'h1;
                        if (isPrbs) begin
                            history <= {history[29:0], rxBit[i]};
                        end else if (rxBit[i] == expected) begin
                            rotor <= wide ? {rotor[18:0], rotor[19]}
                                : {4'h0, rotor[14:0], rotor[15]};
                        end
                        // a miss in pattern mode holds the rotor to slip one bit
                        matchRun <= rxBit[i] == expected ? matchRun + 6'h1 : 6'h0;
                        if (matchRun == `LOCK_RUN) begin
                            state <= V_TRACK;
                        end
                    end
                    V_TRACK: begin
                        if (isPrbs) begin
                            history <= {history[29:0], predicted};
                        end else begin
                            rotor <= wide ? {rotor[18:0], rotor[19]}
                                : {4'h0, rotor[14:0], rotor[15]};
                        end
                        missRun <= rxBit[i] != expected ? missRun + 3'h1 : 3'h0;
                        // lock is lost once misses outrun the retain threshold
                        if (rxBit[i] != expected && missRun >= retainThreshold) begin
                            state <= V_SEARCH;
                            matchRun <= '0;
                            missRun <= '0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        assign patternErr[i] = state == V_TRACK && rxBit[i] != expected;
        assign searchInProgress[i] = state == V_SEARCH;

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                verifyMismatch[i] <= 1'b0;
            end else if (verifierLoad[i]) begin
                verifyMismatch[i] <= 1'b0;
            // four-bit sum so a timeout setting of 7 cannot wrap to a zero limit
            end else if (patternErr[i] || (state == V_SEARCH && searchCount
                    == 16'(({1'b0, activeCfg[i].timeout} + 4'h1) << `SEARCH_LIMIT_SHIFT))) begin
                verifyMismatch[i] <= 1'b1;
            end
        end

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                syncCount <= '0;
            end else if (verifierLoad[i] || !(isPrbs || state == V_TIMING)
                    || syncCount >= period - 31'h1) begin
                syncCount <= '0;
            end else begin
                syncCount <= syncCount + 31'h1;
            end
        end
        assign patternSyncPulse[i] = (isPrbs || state == V_TIMING) && !verifierLoad[i]
            && syncCount < 31'(`SYNC_WIDTH_CYCLES);
    end

    // ****************************************
    // error source, counts and flags
    // ****************************************
    always_comb begin
        case (datapathCheckSelect)
            `CHK_DISPARITY: dpSource = dpErr.disparity;
            `CHK_FIFO_ERROR: dpSource = dpErr.fifoError;
            `CHK_OVERFLOW: dpSource = dpErr.overflow;
            `CHK_UNDERFLOW: dpSource = dpErr.underflow;
            `CHK_DESKEW: dpSource = dpErr.deskew;
            default: dpSource = 4'h0;
        endcase
    end
    // datapath checks replace the pattern checker only when some lane is enabled
    assign laneErr = datapathVerifyEnable != 4'h0
        ? (datapathVerifyEnable & dpSource) : patternErr;

    for (genvar i = 0; i < LANES; i++) begin : g_count
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                bitErrorCount[i] <= '0;
            end else if (clearPulse) begin
                bitErrorCount[i] <= '0;
            end else if (laneErr[i] && bitErrorCount[i] != '1) begin
                // saturates rather than wrapping so a full count is never hidden
                bitErrorCount[i] <= bitErrorCount[i] + 1'b1;
            end
        end
    end

    always_comb begin
        case (testFlagSource)
            `FLAG_ERROR: liveTestFlag = laneErr;
            `FLAG_MISMATCH: liveTestFlag = verifyMismatch;
            `FLAG_SEARCH: liveTestFlag = searchInProgress;
            `FLAG_SYNC: liveTestFlag = patternSyncPulse;
            default: liveTestFlag = 4'h0;
        endcase
    end

    // a flag raised in the clearing cycle survives
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            latchedTestFlag <= 4'h0;
        end else begin
            latchedTestFlag <= (latchedTestFlag & ~{4{stickyFlagClear}}) | liveTestFlag;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        next_readData = `RESET_BYTE;
        case (regAddr)
            `OFS_SYNC_LOAD: next_readData = {patternSyncPulse, verifierLoad};
            `OFS_MISMATCH_SEARCH: next_readData = {verifyMismatch, searchInProgress};
            `OFS_PATTERN_CONFIG: next_readData = {customLenSel, 1'b0, prbsLength, patternSelect};
            `OFS_CUSTOM_LOW: next_readData = customLow;
            `OFS_CUSTOM_MID: next_readData = customMid;
            `OFS_CUSTOM_HIGH: next_readData = {4'h0, customHigh};
            `OFS_THRESHOLD: next_readData = {5'h0, retainThreshold};
            `OFS_TEST_CONTROL: next_readData = {laneAlignDone, 2'h0, errorCounterClear,
                stickyFlagClear, testFlagSource};
            `OFS_DATAPATH_SELECT: next_readData = {datapathVerifyEnable, 1'b0,
                datapathCheckSelect};
            `OFS_TEST_FLAGS: next_readData = {latchedTestFlag, liveTestFlag};
            default: begin
                if (regAddr >= `OFS_COUNT_FIRST && regAddr <= `OFS_COUNT_LAST) begin
                    next_readData = regAddr[0]
                        ? {4'h0, bitErrorCount[regAddr[2:1]][11:8]}
                        : bitErrorCount[regAddr[2:1]][7:0];
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= `RESET_BYTE;
        end else if (regRead) begin
            regRdData <= next_readData;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sync_pulse_width_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(patternSyncPulse[0]) |-> patternSyncPulse[0][*8] ##1 !patternSyncPulse[0])
        else $error("sync pulse not eight cycles");
    load_pass_through_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        verifierLoad[1] |-> activeCfg[1].select == patternSelect
            && activeCfg[1].prbsLength == prbsLength && activeCfg[1].timeout == verifierTimeout)
        else $error("lane settings do not follow register while loading");
    load_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(verifierLoad[0]) ##1 !verifierLoad[0] |-> $stable(activeCfg[0]))
        else $error("lane settings changed after load fell");
    mismatch_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        patternErr[0] && !verifierLoad[0] |=> verifyMismatch[0])
        else $error("mismatch not flagged");
    counter_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        isWr && regAddr == `OFS_TEST_CONTROL && regWrData[`BIT_COUNTER_CLEAR] && !clearPulse
            |=> ##1 bitErrorCount[0] == '0)
        else $error("error count not cleared");
    clear_self_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        errorCounterClear && !$past(isWr) |-> 0)
        else $error("counter clear bit did not return to zero");
    sticky_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        latchedTestFlag[3] && !stickyFlagClear |=> latchedTestFlag[3])
        else $error("latched flag lost without clear");
    source_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        datapathVerifyEnable == 4'h0 && patternErr[1] && !clearPulse
            && bitErrorCount[1] != '1 |=> bitErrorCount[1] == $past(bitErrorCount[1]) + 1'b1)
        else $error("pattern error not counted");
    align_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        regRead && regAddr == `OFS_TEST_CONTROL |=> regRdData[7] == $past(laneAlignDone))
        else $error("align done bit wrong");
endmodule
`default_nettype wire

// ---- testbench/lane_stim_model.sv ----
// far-side receive data model: period-ten clock pattern on every lane
`timescale 1ns/1ps
`default_nettype none

module lane_stim_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic inject,
    output logic [3:0] rxBit
);
    // ********************************
    // pattern source
    // ********************************
    // five zeros then five ones, so the bit order of the pattern word cannot matter
    logic [3:0] phase;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 4'h0;
        end else begin
            phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
        end
    end
    // inject inverts every lane to force misses
    assign rxBit = {4{(phase >= 4'h5) ^ inject}};
endmodule

`default_nettype wire

// ---- testbench/lane_pattern_verifier_bert_tb.sv ----
// self-checking testbench for the lane pattern verifier
`timescale 1ns/1ps
`default_nettype none

module lane_pattern_verifier_bert_tb import lane_verifier_pkg::*;;
    // ********************************
    // stimulus and checks
    // ********************************
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [7:0] rdv;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic laneAlignDone = 1'b0;
    logic inject = 1'b0;
    logic [2:0] verifierTimeout = 3'h0;
    dpErr_type dpErr = '0;
    logic [3:0] rxBit;
    logic [3:0] liveTestFlag;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    int ones;
    logic [7:0] ta [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h15, 8'h0F, 8'h20};
    logic [7:0] tw [9] = '{8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF};
    logic [7:0] te [9] = '{8'hBF, 8'hA5, 8'h5A, 8'h0F, 8'h07, 8'hF7, 8'h07, 8'h00, 8'h00};

    always #5 ref_clk = ~ref_clk;

    lane_pattern_verifier i_dut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
        .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
        .rxBit(rxBit), .verifierTimeout(verifierTimeout), .dpErr(dpErr),
        .laneAlignDone(laneAlignDone), .liveTestFlag(liveTestFlag));

    lane_stim_model i_model (.ref_clk(ref_clk), .resetn(resetn), .inject(inject), .rxBit(rxBit));

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdv = regRdData;
    endtask

    // pulse lane-0 bits of the chosen fields n times
    task automatic pulse(input logic [19:0] v, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            dpErr <= v;
            @(posedge ref_clk);
            dpErr <= '0;
        end
    endtask

    // cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 14; a <= 22; a++) begin
            rd(8'(a));
            chk(rdv, 8'h00);
        end
        for (int i = 0; i < 9; i++) begin
            wr(ta[i], tw[i]);
            rd(ta[i]);
            chk(rdv, te[i]);
        end
        laneAlignDone <= 1'b1;
        rd(8'h15);
        chk(rdv, 8'h87);
        foreach (ta[i]) wr(ta[i], 8'h00);
        // every datapath source, then one reserved code
        for (int c = 0; c < 6; c++) begin
            wr(8'h16, 8'h10 | 8'(c));
            wr(8'h15, 8'h10);
            rd(8'h15);
            chk(rdv & 8'h10, 8'h00);
            rd(8'h18);
            chk(rdv, 8'h00);
            if (c < 5) begin
                pulse(20'h10000 >> (4 * ((c + 1) % 5)), 2);
                pulse(20'h10000 >> (4 * c), 3);
            end else begin
                pulse(20'h11111, 3);
            end
            rd(8'h18);
            chk(rdv, (c < 5) ? 8'h03 : 8'h00);
            rd(8'h19);
            chk(rdv, 8'h00);
        end
        wr(8'h16, 8'h04);
        pulse(20'h00001, 2);
        rd(8'h18);
        chk(rdv, 8'h00);
        rd(8'h17);
        chk(rdv & 8'h10, 8'h10);
        wr(8'h15, 8'h08);
        repeat (2) @(posedge ref_clk);
        rd(8'h17);
        chk(rdv, 8'h00);
        // clock pattern on lanes 0-1, 20-bit custom on 2-3; later setting writes must not matter
        wr(8'h10, 8'h02);
        wr(8'h0E, 8'h03);
        wr(8'h0E, 8'h00);
        wr(8'h11, 8'h1F);
        wr(8'h12, 8'h7C);
        wr(8'h10, 8'h83);
        wr(8'h0E, 8'h0C);
        wr(8'h0E, 8'h00);
        wr(8'h10, 8'h00);
        rd(8'h0F);
        chk(rdv, 8'h0F);
        repeat (100) @(posedge ref_clk);
        rd(8'h0F);
        chk(rdv, 8'h00);
        @(posedge ref_clk);
        inject <= 1'b1;
        repeat (20) @(posedge ref_clk);
        inject <= 1'b0;
        rd(8'h0F);
        chk(rdv & 8'hF0, 8'hF0);
        wr(8'h15, 8'h01);
        #1 chk({4'h0, liveTestFlag}, 8'h0F);
        // seven-bit PRBS never locks to the square wave, so each search times out
        wr(8'h10, 8'h01);
        wr(8'h0E, 8'h0F);
        wr(8'h0E, 8'h00);
        rd(8'h0F);
        chk(rdv, 8'h0F);
        repeat (1030) @(posedge ref_clk);
        rd(8'h0F);
        chk(rdv, 8'hFF);
        // timing-only mode, seven-bit length: 127-cycle period
        wr(8'h10, 8'h04);
        wr(8'h0E, 8'h0F);
        wr(8'h0E, 8'h00);
        ones = 0;
        @(posedge ref_clk);
        regAddr <= 8'h0E;
        regRead <= 1'b1;
        @(posedge ref_clk);
        repeat (254) begin
            @(posedge ref_clk);
            #1 ones += int'(regRdData[4]);
        end
        regRead <= 1'b0;
        chk(8'(ones), 8'h10);
        stop_test();
    end
endmodule

`default_nettype wire
